/* File: shared/bamt_pkg.sv */
`default_nettype none
// ==========================================================================
// burst average / min / max / threshold constants
package bamt_pkg;
    // ======================================================================
    // register indices on the register port
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  OFS_FEATURE = 4'h0;
    localparam logic [3:0]  OFS_COUNT   = 4'h1;
    localparam logic [3:0]  OFS_SOURCE  = 4'h2;
    localparam logic [3:0]  OFS_RATE    = 4'h3;
    localparam logic [3:0]  OFS_THRESH  = 4'h4;
    localparam logic [3:0]  OFS_RES_A   = 4'h5;
    localparam logic [3:0]  OFS_RES_B   = 4'h6;
    localparam logic [3:0]  OFS_RES_C   = 4'h7;

    // ======================================================================
    // field values and reset values
    localparam logic [31:0] FEAT_AMM    = 32'h0000_0003;
    localparam logic [31:0] FEAT_THR    = 32'h0000_0005;
    localparam logic [31:0] FEAT_RST    = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST   = 32'h0000_00c8;
    localparam logic [31:0] COUNT_MAX   = 32'h0000_4000;
    localparam logic [31:0] RATE_RST    = 32'h0000_1770;
    localparam logic [31:0] SOURCE_RST  = 32'h0000_0000;
    localparam logic [31:0] THRESH_RST  = 32'h0000_0000;
    localparam logic [31:0] DIO_BASE    = 32'h0000_07d0;
    // results and threshold are signed q16.16
    localparam logic [31:0] FIX_ONE     = 32'h0001_0000;
    localparam logic [31:0] FIX_ZERO    = 32'h0000_0000;

    // ======================================================================
    // timing
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
    localparam logic [31:0] CLK_HZ_W      = 32'(CLK_HZ);

    // ======================================================================
    // arithmetic widths
    localparam int          CNT_W = 15;
    localparam int          SUM_W = 32 + CNT_W;
    localparam int          IT_W  = 6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DIV  = 2'b11,
        ST_DONE = 2'b10
    } bamt_state_t;
endpackage
`default_nettype wire

/* File: verilog/bamt_core.sv */
// Overview of operation
// - feature value 3 runs a burst giving mean, maximum and minimum
// - sample count per burst, default 200, at most 16384
// - scan rate in samples per second, default 6000
// - burst lasts sample count divided by scan rate
// - mean, maximum, minimum go to first, second, third result
// - only first result read starts a burst; others return latest values
// - first result read stalls until the whole burst is acquired
// - feature value 5 averages a burst and flags above threshold
// - source override zero samples the channel's own analog input
// - nonzero source override is a digital line address to sample
// - flag set only when average strictly exceeds threshold
// - threshold function first result reads 1.0 or 0.0
// - threshold function second result holds latest burst mean
// - digital samples count as 0 or 1, average is a ratio
`default_nettype none
module bamt_core #(
    parameter int DIO_N = 8
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    ce,
    input  wire logic [3:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [31:0]             reg_wdata,
    output var  logic [31:0]             reg_rdata,
    output var  logic                    reg_ready,
    input  wire logic [31:0]             ain_sample,
    input  wire logic [DIO_N-1:0]        dio_in
);
    localparam int SW = bamt_pkg::SUM_W;
    localparam int CW = bamt_pkg::CNT_W;

    // ======================================================================
    // state
    bamt_pkg::bamt_state_t state_ff, nxt_state;
    logic [31:0]           feat_ff, nxt_feat;
    logic [CW-1:0]         count_ff, nxt_count;
    logic [31:0]           rate_ff, nxt_rate;
    logic [31:0]           source_ff, nxt_source;
    logic [31:0]           thresh_ff, nxt_thresh;
    logic [31:0]           res_a_ff, nxt_res_a;
    logic [31:0]           res_b_ff, nxt_res_b;
    logic [31:0]           res_c_ff, nxt_res_c;
    logic [31:0]           rdata_ff, nxt_rdata;
    logic                  ready_ff, nxt_ready;
    logic [31:0]           phase_ff, nxt_phase;
    logic [CW-1:0]         cnt_ff, nxt_cnt;
    logic [SW-1:0]         sum_ff, nxt_sum;
    logic [31:0]           max_ff, nxt_max;
    logic [31:0]           min_ff, nxt_min;
    logic [15:0]           rem_ff, nxt_rem;
    logic [SW-1:0]         quot_ff, nxt_quot;
    logic                  neg_ff, nxt_neg;
    logic [5:0]            it_ff, nxt_it;

    // ======================================================================
    // helpers
    logic [32:0]   phase_sum;
    logic          tick;
    logic [31:0]   sample;
    logic [SW-1:0] sum_add;
    logic [15:0]   rem_sh;
    logic [31:0]   avg_s;
    logic          start_rd;

    function automatic logic [31:0] pick_sample(
        input logic [31:0]      src,
        input logic [31:0]      ain,
        input logic [DIO_N-1:0] dio
    );
        logic [31:0] idx;
        idx = src - bamt_pkg::DIO_BASE;
        pick_sample = bamt_pkg::FIX_ZERO;
        if (src == bamt_pkg::SOURCE_RST) begin
            pick_sample = ain;
        end else if (idx < 32'(DIO_N)) begin
            pick_sample = dio[idx] ? bamt_pkg::FIX_ONE : bamt_pkg::FIX_ZERO;
        end
    endfunction

    function automatic logic is_burst(input logic [31:0] f);
        is_burst = (f == bamt_pkg::FEAT_AMM) || (f == bamt_pkg::FEAT_THR);
    endfunction

    assign phase_sum = {1'b0, phase_ff} + {1'b0, rate_ff};
    // phase accumulator: exact average rate, no divider needed
    assign tick      = (state_ff == bamt_pkg::ST_RUN) &&
                       (phase_sum >= {1'b0, bamt_pkg::CLK_HZ_W});
    assign sample    = pick_sample(source_ff, ain_sample, dio_in);
    assign sum_add   = sum_ff + {{(SW-32){sample[31]}}, sample};
    assign rem_sh    = {rem_ff[14:0], quot_ff[SW-1]};
    assign avg_s     = neg_ff ? (32'h0 - quot_ff[31:0]) : quot_ff[31:0];
    assign start_rd  = (state_ff == bamt_pkg::ST_IDLE) && reg_rd &&
                       !reg_wr && (reg_addr == bamt_pkg::OFS_RES_A) &&
                       is_burst(feat_ff) && !ready_ff;

    // ======================================================================
    // next state
    always_comb begin
        nxt_state  = state_ff;
        nxt_feat   = feat_ff;
        nxt_count  = count_ff;
        nxt_rate   = rate_ff;
        nxt_source = source_ff;
        nxt_thresh = thresh_ff;
        nxt_res_a  = res_a_ff;
        nxt_res_b  = res_b_ff;
        nxt_res_c  = res_c_ff;
        nxt_rdata  = rdata_ff;
        nxt_ready  = 1'b0;
        nxt_phase  = phase_ff;
        nxt_cnt    = cnt_ff;
        nxt_sum    = sum_ff;
        nxt_max    = max_ff;
        nxt_min    = min_ff;
        nxt_rem    = rem_ff;
        nxt_quot   = quot_ff;
        nxt_neg    = neg_ff;
        nxt_it     = it_ff;
        unique case (state_ff)
            bamt_pkg::ST_IDLE: begin
                // a request still held in its answer cycle is not retaken
                if (reg_wr && !ready_ff) begin
                    nxt_ready = 1'b1;
                    case (reg_addr)
                        bamt_pkg::OFS_FEATURE: nxt_feat = reg_wdata;
                        bamt_pkg::OFS_COUNT: begin
                            // clamp keeps the divider and counter in range
                            if (reg_wdata > bamt_pkg::COUNT_MAX) begin
                                nxt_count = CW'(bamt_pkg::COUNT_MAX);
                            end else if (reg_wdata == 32'h0) begin
                                nxt_count = CW'(1);
                            end else begin
                                nxt_count = reg_wdata[CW-1:0];
                            end
                        end
                        bamt_pkg::OFS_SOURCE: nxt_source = reg_wdata;
                        bamt_pkg::OFS_RATE: begin
                            if (reg_wdata > bamt_pkg::CLK_HZ_W) begin
                                nxt_rate = bamt_pkg::CLK_HZ_W;
                            end else if (reg_wdata == 32'h0) begin
                                nxt_rate = 32'h1;
                            end else begin
                                nxt_rate = reg_wdata;
                            end
                        end
                        bamt_pkg::OFS_THRESH: nxt_thresh = reg_wdata;
                        default: ;
                    endcase
                end else if (start_rd) begin
                    nxt_state = bamt_pkg::ST_RUN;
                    nxt_phase = 32'h0;
                    nxt_cnt   = '0;
                    nxt_sum   = '0;
                end else if (reg_rd && !ready_ff) begin
                    nxt_ready = 1'b1;
                    case (reg_addr)
                        bamt_pkg::OFS_FEATURE: nxt_rdata = feat_ff;
                        bamt_pkg::OFS_COUNT:   nxt_rdata = 32'(count_ff);
                        bamt_pkg::OFS_SOURCE:  nxt_rdata = source_ff;
                        bamt_pkg::OFS_RATE:    nxt_rdata = rate_ff;
                        bamt_pkg::OFS_THRESH:  nxt_rdata = thresh_ff;
                        bamt_pkg::OFS_RES_A:   nxt_rdata = res_a_ff;
                        bamt_pkg::OFS_RES_B:   nxt_rdata = res_b_ff;
                        bamt_pkg::OFS_RES_C:   nxt_rdata = res_c_ff;
                        default:               nxt_rdata = 32'h0;
                    endcase
                end
            end
            bamt_pkg::ST_RUN: begin
                // no answer while running: the read stalls
                nxt_phase = phase_sum[31:0];
                if (tick) begin
                    nxt_phase = 32'(phase_sum - {1'b0, bamt_pkg::CLK_HZ_W});
                    nxt_sum   = sum_add;
                    nxt_cnt   = cnt_ff + CW'(1);
                    if (cnt_ff == '0) begin
                        nxt_max = sample;
                        nxt_min = sample;
                    end else begin
                        if ($signed(sample) > $signed(max_ff)) begin
                            nxt_max = sample;
                        end
                        if ($signed(sample) < $signed(min_ff)) begin
                            nxt_min = sample;
                        end
                    end
                    if (cnt_ff + CW'(1) == count_ff) begin
                        nxt_state = bamt_pkg::ST_DIV;
                        nxt_neg   = sum_add[SW-1];
                        nxt_quot  = sum_add[SW-1] ? (SW'(0) - sum_add)
                                                  : sum_add;
                        nxt_rem   = 16'h0;
                        nxt_it    = 6'h0;
                    end
                end
            end
            bamt_pkg::ST_DIV: begin
                // restoring division, one quotient bit per cycle
                nxt_quot = {quot_ff[SW-2:0], 1'b0};
                nxt_rem  = rem_sh;
                if (rem_sh >= {1'b0, count_ff}) begin
                    nxt_rem     = rem_sh - {1'b0, count_ff};
                    nxt_quot[0] = 1'b1;
                end
                nxt_it = it_ff + 6'h1;
                if (it_ff == 6'(SW - 1)) begin
                    nxt_state = bamt_pkg::ST_DONE;
                end
            end
            bamt_pkg::ST_DONE: begin
                nxt_state = bamt_pkg::ST_IDLE;
                nxt_ready = 1'b1;
                if (feat_ff == bamt_pkg::FEAT_AMM) begin
                    nxt_res_a = avg_s;
                    nxt_res_b = max_ff;
                    nxt_res_c = min_ff;
                    nxt_rdata = avg_s;
                end else begin
                    nxt_res_a = ($signed(avg_s) > $signed(thresh_ff)) ?
                                bamt_pkg::FIX_ONE : bamt_pkg::FIX_ZERO;
                    nxt_res_b = avg_s;
                    nxt_rdata = nxt_res_a;
                end
            end
        endcase
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff  <= bamt_pkg::ST_IDLE;
            feat_ff   <= bamt_pkg::FEAT_RST;
            count_ff  <= CW'(bamt_pkg::COUNT_RST);
            rate_ff   <= bamt_pkg::RATE_RST;
            source_ff <= bamt_pkg::SOURCE_RST;
            thresh_ff <= bamt_pkg::THRESH_RST;
            res_a_ff  <= 32'h0;
            res_b_ff  <= 32'h0;
            res_c_ff  <= 32'h0;
            rdata_ff  <= 32'h0;
            ready_ff  <= 1'b0;
            phase_ff  <= 32'h0;
            cnt_ff    <= '0;
            sum_ff    <= '0;
            max_ff    <= 32'h0;
            min_ff    <= 32'h0;
            rem_ff    <= 16'h0;
            quot_ff   <= '0;
            neg_ff    <= 1'b0;
            it_ff     <= 6'h0;
        end else if (ce) begin
            state_ff  <= nxt_state;
            feat_ff   <= nxt_feat;
            count_ff  <= nxt_count;
            rate_ff   <= nxt_rate;
            source_ff <= nxt_source;
            thresh_ff <= nxt_thresh;
            res_a_ff  <= nxt_res_a;
            res_b_ff  <= nxt_res_b;
            res_c_ff  <= nxt_res_c;
            rdata_ff  <= nxt_rdata;
            ready_ff  <= nxt_ready;
            phase_ff  <= nxt_phase;
            cnt_ff    <= nxt_cnt;
            sum_ff    <= nxt_sum;
            max_ff    <= nxt_max;
            min_ff    <= nxt_min;
            rem_ff    <= nxt_rem;
            quot_ff   <= nxt_quot;
            neg_ff    <= nxt_neg;
            it_ff     <= nxt_it;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_ready = ready_ff;

    // ======================================================================
    // checks
    sequence s_start_read;
        start_rd && ce;
    endsequence

    sequence s_run_entry;
        ##1 (state_ff == bamt_pkg::ST_RUN) && !ready_ff;
    endsequence

    property p_start;
        @(posedge clk) disable iff (!resetn)
        s_start_read |-> s_run_entry;
    endproperty
    a_start: assert property (p_start)
        else $error("burst did not start on first result read");

    property p_stall;
        @(posedge clk) disable iff (!resetn)
        (state_ff == bamt_pkg::ST_RUN || state_ff == bamt_pkg::ST_DIV)
            |-> !ready_ff;
    endproperty
    a_stall: assert property (p_stall)
        else $error("read answered before burst end");

    property p_cnt_bound;
        @(posedge clk) disable iff (!resetn)
        (state_ff == bamt_pkg::ST_RUN) |-> (cnt_ff < count_ff);
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("sample count overran setting");

    property p_count_clamp;
        @(posedge clk) disable iff (!resetn)
        (ce && state_ff == bamt_pkg::ST_IDLE && reg_wr &&
         reg_addr == bamt_pkg::OFS_COUNT && reg_wdata > bamt_pkg::COUNT_MAX)
            |=> (32'(count_ff) == bamt_pkg::COUNT_MAX);
    endproperty
    a_count_clamp: assert property (p_count_clamp)
        else $error("sample count not limited to maximum");

    property p_only_tick;
        @(posedge clk) disable iff (!resetn)
        (state_ff == bamt_pkg::ST_RUN && !tick)
            |=> $stable(cnt_ff) && $stable(sum_ff);
    endproperty
    a_only_tick: assert property (p_only_tick)
        else $error("sample taken without scan tick");

    property p_minmax;
        @(posedge clk) disable iff (!resetn)
        (state_ff == bamt_pkg::ST_RUN && cnt_ff != '0)
            |-> ($signed(min_ff) <= $signed(max_ff));
    endproperty
    a_minmax: assert property (p_minmax)
        else $error("minimum above maximum");

    property p_amm_result;
        @(posedge clk) disable iff (!resetn)
        (ce && state_ff == bamt_pkg::ST_DONE && feat_ff == bamt_pkg::FEAT_AMM)
            |=> (res_b_ff == $past(max_ff)) && (res_c_ff == $past(min_ff))
                && ready_ff && (rdata_ff == res_a_ff);
    endproperty
    a_amm_result: assert property (p_amm_result)
        else $error("mean/max/min not placed in results");

    property p_flag;
        @(posedge clk) disable iff (!resetn)
        (ce && state_ff == bamt_pkg::ST_DONE && feat_ff == bamt_pkg::FEAT_THR)
            |=> (res_a_ff == (($signed($past(avg_s)) >
                               $signed($past(thresh_ff))) ?
                              bamt_pkg::FIX_ONE : bamt_pkg::FIX_ZERO))
                && (res_b_ff == $past(avg_s));
    endproperty
    a_flag: assert property (p_flag)
        else $error("threshold flag wrong");

    property p_other_read;
        @(posedge clk) disable iff (!resetn)
        (ce && state_ff == bamt_pkg::ST_IDLE && reg_rd && !reg_wr &&
         reg_addr == bamt_pkg::OFS_RES_B && !ready_ff)
            |=> ready_ff && (rdata_ff == res_b_ff) &&
                (state_ff == bamt_pkg::ST_IDLE);
    endproperty
    a_other_read: assert property (p_other_read)
        else $error("second result read misbehaved");

    property p_ain_source;
        @(posedge clk) disable iff (!resetn)
        (ce && tick && source_ff == bamt_pkg::SOURCE_RST)
            |=> (sum_ff == $past(sum_ff) +
                 {{(SW-32){$past(ain_sample[31])}}, $past(ain_sample)});
    endproperty
    a_ain_source: assert property (p_ain_source)
        else $error("analog sample not accumulated");
endmodule
`default_nettype wire

/* File: testbench/burst_average_min_max_threshold_test.sv */
`default_nettype none
module burst_average_min_max_threshold_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // clock, reset and driven inputs
    logic        clk        = 1'b0;
    logic        resetn     = 1'b0;
    logic        ce         = 1'b1;
    logic [3:0]  reg_addr   = 4'h0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [31:0] reg_wdata  = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        reg_ready;
    logic [31:0] ain_sample = 32'h0000_0000;
    logic [7:0]  dio_in     = 8'h00;
    logic        use_pat    = 1'b0;
    logic [31:0] ain_const  = 32'h0000_0000;
    logic [1:0]  ph         = 2'h0;
    logic [31:0] pat [4]    = '{32'h0001_8000, 32'hfffe_0000,
                                32'h0003_4000, 32'h0000_4000};
    logic [3:0]  dpat       = 4'b0111;
    int          errors     = 0;
    int          checked    = 0;

    always #25 clk = ~clk;

    bamt_core #(.DIO_N(8)) DUT (
        .clk        (clk),
        .resetn     (resetn),
        .ce         (ce),
        .reg_addr   (reg_addr),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_wdata  (reg_wdata),
        .reg_rdata  (reg_rdata),
        .reg_ready  (reg_ready),
        .ain_sample (ain_sample),
        .dio_in     (dio_in)
    );

    // ======================================================================
    // stimulus source: period-4 patterns so any 4-sample window agrees
    always @(posedge clk) begin
        ph <= ph + 2'd1;
        ain_sample <= use_pat ? pat[ph] : ain_const;
        // line zero is the inverse, so a wrong line choice shows
        dio_in <= {6'h00, dpat[ph], ~dpat[ph]};
    end

    // ======================================================================
    // helpers
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chkr(input string nm, input int lo, input int hi,
                        input int got);
        checked++;
        if (got < lo || got > hi) begin
            errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d",
                     nm, lo, hi, got);
        end
    endtask

    // request stands until ready is seen, then drops for one edge so a
    // following call never reassigns it in the same time step
    task automatic acc(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output int n);
        n = 0;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= wr;
        reg_rd    <= ~wr;
        @(posedge clk);
        do begin
            @(posedge clk);
            n++;
        end while (reg_ready !== 1'b1 && n < 4000);
        q = reg_rdata;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
        if (n >= 4000) begin
            errors++;
            $display("MISMATCH reg_ready expected 1 seen timeout");
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        int          n;
        acc(1'b1, a, d, q, n);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q,
                      output int n);
        acc(1'b0, a, 32'h0000_0000, q, n);
    endtask

    task automatic setup(input logic [31:0] f, input logic [31:0] c,
                         input logic [31:0] r, input logic [31:0] s,
                         input logic [31:0] t);
        wr(bamt_pkg::OFS_FEATURE, f);
        wr(bamt_pkg::OFS_COUNT, c);
        wr(bamt_pkg::OFS_RATE, r);
        wr(bamt_pkg::OFS_SOURCE, s);
        wr(bamt_pkg::OFS_THRESH, t);
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] q;
        int          n;
        rd(bamt_pkg::OFS_FEATURE, q, n);
        chk("feature", 32'h0000_0000, q);
        rd(bamt_pkg::OFS_COUNT, q, n);
        chk("count", 32'h0000_00c8, q);
        rd(bamt_pkg::OFS_RATE, q, n);
        chk("rate", 32'h0000_1770, q);
        rd(bamt_pkg::OFS_SOURCE, q, n);
        chk("source", 32'h0000_0000, q);
        rd(bamt_pkg::OFS_THRESH, q, n);
        chk("thresh", 32'h0000_0000, q);
        // three frozen edges hold off the take, so the answer slips by three
        ce <= 1'b0;
        fork
            rd(bamt_pkg::OFS_THRESH, q, n);
            begin
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        chkr("ce freeze latency", 4, 4, n);
        chk("ce thresh", 32'h0000_0000, q);
        wr(4'h8, 32'h1234_5678);
        rd(4'h8, q, n);
        chk("unmapped", 32'h0000_0000, q);
        wr(bamt_pkg::OFS_RES_B, 32'h1234_5678);
        rd(bamt_pkg::OFS_RES_B, q, n);
        chk("res_b ro", 32'h0000_0000, q);
        wr(bamt_pkg::OFS_COUNT, 32'h0000_5000);
        rd(bamt_pkg::OFS_COUNT, q, n);
        chk("count clamp", 32'h0000_4000, q);
        $display("test reset done");
    endtask

    task automatic t_amm();
        logic [31:0] q;
        int          n;
        use_pat <= 1'b1;
        setup(32'h3, 32'h4, 32'h0131_2d00, 32'h0, 32'h0);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("mean", 32'h0000_c000, q);
        chkr("burst latency", 4, 64, n);
        rd(bamt_pkg::OFS_RES_B, q, n);
        chk("max", 32'h0003_4000, q);
        chkr("res_b latency", 1, 1, n);
        rd(bamt_pkg::OFS_RES_C, q, n);
        chk("min", 32'hfffe_0000, q);
        // new burst must reseed min and max from its own samples
        use_pat   <= 1'b0;
        ain_const <= 32'h0000_8000;
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("mean2", 32'h0000_8000, q);
        rd(bamt_pkg::OFS_RES_B, q, n);
        chk("max2", 32'h0000_8000, q);
        rd(bamt_pkg::OFS_RES_C, q, n);
        chk("min2", 32'h0000_8000, q);
        $display("test amm done");
    endtask

    task automatic t_rate();
        logic [31:0] q;
        int          n;
        wr(bamt_pkg::OFS_RATE, 32'h000f_4240);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chkr("slow latency", 60, 140, n);
        chk("slow mean", 32'h0000_8000, q);
        $display("test rate done");
    endtask

    task automatic t_thr();
        logic [31:0] q;
        int          n;
        ain_const <= 32'h0001_4000;
        setup(32'h5, 32'h4, 32'h0131_2d00, 32'h0, 32'h0001_2666);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("flag above", 32'h0001_0000, q);
        rd(bamt_pkg::OFS_RES_B, q, n);
        chk("thr mean", 32'h0001_4000, q);
        rd(bamt_pkg::OFS_RES_C, q, n);
        chk("res_c kept", 32'h0000_8000, q);
        wr(bamt_pkg::OFS_THRESH, 32'h0001_4000);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("flag equal", 32'h0000_0000, q);
        $display("test threshold done");
    endtask

    task automatic t_dig();
        logic [31:0] q;
        int          n;
        ain_const <= 32'h0005_0000;
        setup(32'h5, 32'h4, 32'h0131_2d00, 32'h0000_07d1, 32'h0000_a666);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("dig flag", 32'h0001_0000, q);
        rd(bamt_pkg::OFS_RES_B, q, n);
        chk("dig ratio", 32'h0000_c000, q);
        wr(bamt_pkg::OFS_THRESH, 32'h0000_c000);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chk("dig flag eq", 32'h0000_0000, q);
        // other features must not start a burst on a first result read
        wr(bamt_pkg::OFS_FEATURE, 32'h0);
        rd(bamt_pkg::OFS_RES_A, q, n);
        chkr("idle latency", 1, 1, n);
        chk("idle res_a", 32'h0000_0000, q);
        $display("test digital done");
    endtask

    // ======================================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_amm();
        t_rate();
        t_thr();
        t_dig();
        end_sim();
    end

    // tests need about 600 cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_sim();
    end
endmodule
`default_nettype wire
